// ==== ccbt_can_control_bit_timing.v ====
// CAN controller mode control and bit-timing configuration, AXI4-Lite register slave.
// Assumes the protocol engine consumes the timing outputs and reports activity inputs.
`timescale 1ns/1ps
`default_nettype none
`include "ccbt_map.vh"

// Contract
// - Requested mode codes: 111 listen-all, 100 config, 011, 010, 001, 000.
// - Read-only mode status shows mode in force, same codes.
// - Abort bit signals all transmit buffers; cleared when aborts complete.
// - Capture enable stores timer on valid receive; clear halts timer.
// - Enable bit turns module on; clear takes effect after transaction ends.
// - Busy bit reads one until module is completely disabled.
// - Stop-in-idle halts module during system idle; else keeps running.
// - Five-bit data-count field; 0 to 18 valid, 19 and above invalid.
// - Wake-up filter enable routes bus line through a filter.
// - Segment fields give field plus one quanta, 1 to 8.
// - Phase-2 select zero: phase 2 = max(phase 1, processing time).
// - Sampling-mode bit one samples three times, zero once.
// - Jump width is field plus one quanta, 1 to 4.
// - Quantum is 2 times (prescaler plus one) system clocks.
// - Timing register writable only while status shows configuration.
// - Clear, set, invert aliases at offsets 0x4, 0x8, 0xC.
// - Mode-change flag raised when status updates to requested mode.
module ccbt_can_control_bit_timing (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire [11:0] s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [11:0] s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire        system_idle,
    input  wire        engine_busy,
    input  wire        tx_aborts_done,
    input  wire        rx_valid_msg,
    input  wire        can_rx,
    output reg         abort_all_tx,
    output reg         engine_enable,
    output reg  [2:0]  mode_status,
    output reg         mode_change_flag,
    output reg  [15:0] timestamp_timer,
    output reg  [15:0] rx_timestamp,
    output reg         rx_timestamp_valid,
    output reg  [4:0]  filter_data_bit_count,
    output reg         filter_count_invalid,
    output reg         wake_line,
    output reg         quantum_tick,
    output reg  [3:0]  propagation_seg_len,
    output reg  [3:0]  phase_seg1_len,
    output reg  [3:0]  phase_seg2_len,
    output reg  [2:0]  jump_width,
    output reg         triple_sample_sel
);
    parameter WAKE_FILTER_LEN = 4;
    // Register selects decoded from the upper address bits
    localparam REG_NONE   = 2'h0;
    localparam REG_CTRL   = 2'h1;
    localparam REG_TIMING = 2'h2;
    localparam REG_STATUS = 2'h3;

    reg  [31:0] ctrl;
    reg  [31:0] timing;
    reg  [3:0]  stop_cnt;
    reg         active;
    reg  [6:0]  tq_cnt;
    reg  [WAKE_FILTER_LEN-1:0] wake_hist;
    reg         aw_held;
    reg         w_held;
    reg  [11:0] aw_addr;
    reg  [31:0] w_data;
    reg  [3:0]  w_strb;
    wire [2:0]  requested_mode = ctrl[`CCBT_CTRL_REQ_LO+2:`CCBT_CTRL_REQ_LO];
    wire        module_on = ctrl[`CCBT_CTRL_ON];
    wire        run = active && !(ctrl[`CCBT_CTRL_STOP_IN_IDLE] && system_idle);
    wire        do_write = aw_held && w_held && !s_axi_bvalid;
    wire [31:0] wmask_bytes = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
    wire [1:0]  alias_sel = aw_addr[3:2];
    wire        hit_ctrl = (reg_index(aw_addr) == REG_CTRL);
    wire        hit_timing = (reg_index(aw_addr) == REG_TIMING);
    wire        hit_status = (reg_index(aw_addr) == REG_STATUS) && (alias_sel == 2'h0);
    wire [5:0]  prescaler = timing[5:0];

    // Applies a base write or a clear, set or invert alias to a register
    function [31:0] apply_alias;
        input [31:0] old;
        input [31:0] data;
        input [31:0] mask;
        input [1:0]  sel;
        reg   [31:0] m;
        begin
            m = data & mask;
            case (sel)
                2'h0:            apply_alias = (old & ~mask) | m;
                `CCBT_ALIAS_CLR: apply_alias = old & ~m;
                `CCBT_ALIAS_SET: apply_alias = old | m;
                `CCBT_ALIAS_INV: apply_alias = old ^ m;
                default:         apply_alias = old;
            endcase
        end
    endfunction

    // Length in quanta of a three-bit segment field
    function [3:0] seg_len;
        input [2:0] field;
        begin
            seg_len = {1'b0, field} + 4'h1;
        end
    endfunction

    // Selects the register behind a byte address; the low nibble picks an alias
    function [1:0] reg_index;
        input [11:0] addr;
        begin
            case ({addr[11:4], 4'h0})
                `CCBT_CTRL_OFS:   reg_index = REG_CTRL;
                `CCBT_TIMING_OFS: reg_index = REG_TIMING;
                `CCBT_STATUS_OFS: reg_index = REG_STATUS;
                default:          reg_index = REG_NONE;
            endcase
        end
    endfunction

    assign s_axi_awready = !aw_held;
    assign s_axi_wready  = !w_held;
    assign s_axi_arready = !s_axi_rvalid;

    // Write channel: address and data taken in either order
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            aw_addr      <= 12'h000;
            w_data       <= 32'h00000000;
            w_strb       <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `CCBT_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && !aw_held) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !w_held) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                // Status writes are legal; a status alias or a hole answers an error
                s_axi_bresp  <= (hit_ctrl || hit_timing || hit_status) ? `CCBT_RESP_OKAY
                                                                       : `CCBT_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Control register, mode sequencing and shutdown
    always @(posedge aclk) begin
        if (!aresetn) begin
            ctrl             <= {5'h00, `CCBT_MODE_CONFIG, 24'h000000};
            timing           <= 32'h00000000;
            mode_status      <= `CCBT_MODE_CONFIG;
            mode_change_flag <= 1'b0;
            active           <= 1'b0;
            stop_cnt         <= 4'h0;
        end else begin
            if (do_write && hit_ctrl)
                ctrl <= apply_alias(ctrl, w_data, wmask_bytes & `CCBT_CTRL_WMASK, alias_sel);
            else if (ctrl[`CCBT_CTRL_ABORT] && (tx_aborts_done || !active))
                ctrl[`CCBT_CTRL_ABORT] <= 1'b0;
            if (do_write && hit_timing && mode_status == `CCBT_MODE_CONFIG)
                timing <= apply_alias(timing, w_data, wmask_bytes & `CCBT_TIM_WMASK, alias_sel);
            // Reserved request codes are not honoured, status keeps its value
            if (mode_status != requested_mode && requested_mode != 3'h5
                && requested_mode != 3'h6 && !engine_busy) begin
                mode_status      <= requested_mode;
                mode_change_flag <= 1'b1;
            end else if (do_write && hit_status && w_data[0] && w_strb[0]) begin
                mode_change_flag <= 1'b0;
            end
            // Shutdown waits for the engine to finish and a short drain
            if (module_on) begin
                active   <= 1'b1;
                stop_cnt <= `CCBT_STOP_CYCLES;
            end else if (active && !engine_busy) begin
                if (stop_cnt == 4'h0)
                    active <= 1'b0;
                else
                    stop_cnt <= stop_cnt - 4'h1;
            end
        end
    end

    // Timing outputs, prescaler and timestamps
    always @(posedge aclk) begin
        if (!aresetn) begin
            abort_all_tx          <= 1'b0;
            engine_enable         <= 1'b0;
            tq_cnt                <= 7'h00;
            quantum_tick          <= 1'b0;
            timestamp_timer       <= 16'h0000;
            rx_timestamp          <= 16'h0000;
            rx_timestamp_valid    <= 1'b0;
            filter_data_bit_count <= 5'h00;
            filter_count_invalid  <= 1'b0;
            propagation_seg_len   <= 4'h1;
            phase_seg1_len        <= 4'h1;
            phase_seg2_len        <= 4'h1;
            jump_width            <= 3'h1;
            triple_sample_sel     <= 1'b0;
            wake_hist             <= {WAKE_FILTER_LEN{1'b1}};
            wake_line             <= 1'b1;
        end else begin
            abort_all_tx  <= ctrl[`CCBT_CTRL_ABORT];
            engine_enable <= run;
            // Quantum period is 2*(prescaler+1) clocks
            if (!run || tq_cnt >= {prescaler, 1'b1}) begin
                tq_cnt       <= 7'h00;
                quantum_tick <= run;
            end else begin
                tq_cnt       <= tq_cnt + 7'h01;
                quantum_tick <= 1'b0;
            end
            if (ctrl[`CCBT_CTRL_CAP] && run)
                timestamp_timer <= timestamp_timer + 16'h0001;
            rx_timestamp_valid <= ctrl[`CCBT_CTRL_CAP] && rx_valid_msg;
            if (ctrl[`CCBT_CTRL_CAP] && rx_valid_msg)
                rx_timestamp <= timestamp_timer;
            filter_data_bit_count <= ctrl[4:0];
            filter_count_invalid  <= (ctrl[4:0] > 5'h12);
            propagation_seg_len <= seg_len(timing[`CCBT_TIM_PROP_LO+2:`CCBT_TIM_PROP_LO]);
            phase_seg1_len <= seg_len(timing[`CCBT_TIM_SEG1_LO+2:`CCBT_TIM_SEG1_LO]);
            if (timing[`CCBT_TIM_P2SEL])
                phase_seg2_len <= seg_len(timing[`CCBT_TIM_SEG2_LO+2:`CCBT_TIM_SEG2_LO]);
            else if (seg_len(timing[`CCBT_TIM_SEG1_LO+2:`CCBT_TIM_SEG1_LO]) > `CCBT_IPT_TQ)
                phase_seg2_len <= seg_len(timing[`CCBT_TIM_SEG1_LO+2:`CCBT_TIM_SEG1_LO]);
            else
                phase_seg2_len <= `CCBT_IPT_TQ;
            jump_width <= {1'b0, timing[`CCBT_TIM_SJW_LO+1:`CCBT_TIM_SJW_LO]} + 3'h1;
            // Relies on software avoiding prescaler below 2 here
            triple_sample_sel <= timing[`CCBT_TIM_SAM];
            // Line filter: a level must persist for the whole window
            wake_hist <= {wake_hist[WAKE_FILTER_LEN-2:0], can_rx};
            if (!timing[`CCBT_TIM_WAKEUP_LINE_FILTER_EN])
                wake_line <= can_rx;
            else if (&wake_hist)
                wake_line <= 1'b1;
            else if (~|wake_hist)
                wake_line <= 1'b0;
        end
    end

    // Read channel; alias reads return zero
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= `CCBT_RESP_OKAY;
        end else if (s_axi_arvalid && !s_axi_rvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= `CCBT_RESP_OKAY;
            s_axi_rdata  <= 32'h00000000;
            // Aliases read as zero; software must not rely on them
            case (reg_index(s_axi_araddr))
                REG_CTRL:
                    if (s_axi_araddr[3:0] == 4'h0)
                        s_axi_rdata <= (ctrl & `CCBT_CTRL_WMASK)
                                     | ({29'h0, mode_status} << `CCBT_CTRL_STAT_LO)
                                     | ({31'h0, active} << `CCBT_CTRL_BUSY);
                REG_TIMING:
                    if (s_axi_araddr[3:0] == 4'h0)
                        s_axi_rdata <= timing & `CCBT_TIM_WMASK;
                REG_STATUS:
                    if (s_axi_araddr[3:0] == 4'h0)
                        s_axi_rdata <= {31'h0, mode_change_flag};
                    else
                        s_axi_rresp <= `CCBT_RESP_SLVERR;
                default:
                    s_axi_rresp <= `CCBT_RESP_SLVERR;
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule // ccbt_can_control_bit_timing
`default_nettype wire

// ==== ccbt_map.vh ====
// Register map, field positions and reset values of the CAN control and bit-timing block.
// Included by the design file; holds definitions only.
`ifndef CCBT_MAP_VH
`define CCBT_MAP_VH

`define CCBT_CTRL_OFS        12'h000
`define CCBT_TIMING_OFS      12'h010
`define CCBT_STATUS_OFS      12'h020
`define CCBT_ALIAS_CLR       2'h1
`define CCBT_ALIAS_SET       2'h2
`define CCBT_ALIAS_INV       2'h3

`define CCBT_CTRL_ABORT      27
`define CCBT_CTRL_REQ_LO     24
`define CCBT_CTRL_STAT_LO    21
`define CCBT_CTRL_CAP        20
`define CCBT_CTRL_ON         15
`define CCBT_CTRL_STOP_IN_IDLE      13
`define CCBT_CTRL_BUSY       11
`define CCBT_CTRL_WMASK      32'h0f10a01f

`define CCBT_TIM_WAKEUP_LINE_FILTER_EN      22
`define CCBT_TIM_SEG2_LO     16
`define CCBT_TIM_P2SEL       15
`define CCBT_TIM_SAM         14
`define CCBT_TIM_SEG1_LO     11
`define CCBT_TIM_PROP_LO     8
`define CCBT_TIM_SJW_LO      6
`define CCBT_TIM_WMASK       32'h0047ffff

`define CCBT_MODE_NORMAL     3'h0
`define CCBT_MODE_DISABLE    3'h1
`define CCBT_MODE_LOOPBACK   3'h2
`define CCBT_MODE_LISTEN     3'h3
`define CCBT_MODE_CONFIG     3'h4
`define CCBT_MODE_LISTEN_ALL 3'h7

`define CCBT_STOP_CYCLES     4'h8
`define CCBT_IPT_TQ          4'h2
`define CCBT_RESP_OKAY       2'h0
`define CCBT_RESP_SLVERR     2'h2

`endif

// ==== ccbt_bus_node.sv ====
// Far-side CAN node: keeps the bus recessive and drives dominant bursts on command.
// Assumes the bench raises go for one clock with len already set.
`timescale 1ns/1ps
`default_nettype none
module ccbt_bus_node (
    input  wire logic       aclk,
    input  wire logic       go,
    input  wire logic [7:0] len,
    output wire logic       can_rx
);
    logic [7:0] cnt = 8'h00;
    always @(posedge aclk) begin
        cnt <= go ? len : (cnt != 8'h00 ? cnt - 8'h01 : 8'h00);
    end
    // Released bus floats back to recessive through the transceiver pull-up
    assign can_rx = (cnt == 8'h00);
endmodule // ccbt_bus_node
`default_nettype wire

// ==== ccbt_monitor.sv ====
// Assertion checker for the CAN control and bit-timing block.
// Sees only the top module's ports; one clock, synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module ccbt_monitor (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_wvalid,
    input wire logic        tx_aborts_done,
    input wire logic        rx_valid_msg,
    input wire logic        engine_enable,
    input wire logic        abort_all_tx,
    input wire logic [2:0]  mode_status,
    input wire logic        mode_change_flag,
    input wire logic [15:0] timestamp_timer,
    input wire logic        rx_timestamp_valid,
    input wire logic [4:0]  filter_data_bit_count,
    input wire logic        filter_count_invalid,
    input wire logic        quantum_tick,
    input wire logic [3:0]  phase_seg1_len,
    input wire logic [2:0]  jump_width
);
    default clocking @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    property p_mode_legal;
        mode_status != 3'h5 && mode_status != 3'h6;
    endproperty
    a_mode_legal: assert property (p_mode_legal) else $error("reserved mode status");
    property p_flag;
        $changed(mode_status) |-> mode_change_flag;
    endproperty
    a_flag: assert property (p_flag) else $error("mode change without flag");
    property p_jw;
        jump_width >= 3'h1 && jump_width <= 3'h4;
    endproperty
    a_jw: assert property (p_jw) else $error("jump width out of range");
    property p_tick;
        quantum_tick |=> !quantum_tick;
    endproperty
    a_tick: assert property (p_tick) else $error("quantum shorter than two clocks");
    property p_stamp;
        rx_timestamp_valid |-> $past(rx_valid_msg);
    endproperty
    a_stamp: assert property (p_stamp) else $error("stamp without message");
    property p_halt;
        !engine_enable |-> $stable(timestamp_timer);
    endproperty
    a_halt: assert property (p_halt) else $error("timer runs while stopped");
    property p_abort;
        abort_all_tx && tx_aborts_done && !s_axi_awvalid && !s_axi_wvalid |-> ##[1:3] !abort_all_tx;
    endproperty
    a_abort: assert property (p_abort) else $error("abort not cleared");
    property p_count;
        filter_count_invalid == (filter_data_bit_count > 5'h12);
    endproperty
    a_count: assert property (p_count) else $error("count validity wrong");
    // Two cycles out of configuration cover a write already in flight
    property p_lock;
        mode_status != 3'h4 && $past(mode_status) != 3'h4 |=> $stable(jump_width) && $stable(phase_seg1_len);
    endproperty
    a_lock: assert property (p_lock) else $error("timing changed outside config");
    c_mode: cover property ($changed(mode_status));
    c_tick: cover property (quantum_tick);
    c_abort: cover property ($fell(abort_all_tx));
endmodule // ccbt_monitor
bind ccbt_can_control_bit_timing ccbt_monitor u_mon (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_wvalid(s_axi_wvalid),
    .tx_aborts_done(tx_aborts_done), .rx_valid_msg(rx_valid_msg), .engine_enable(engine_enable),
    .abort_all_tx(abort_all_tx), .mode_status(mode_status), .mode_change_flag(mode_change_flag),
    .timestamp_timer(timestamp_timer), .rx_timestamp_valid(rx_timestamp_valid),
    .filter_data_bit_count(filter_data_bit_count), .filter_count_invalid(filter_count_invalid),
    .quantum_tick(quantum_tick), .phase_seg1_len(phase_seg1_len), .jump_width(jump_width)
);
`default_nettype wire

// ==== ccbt_can_control_bit_timing_tb.sv ====
// Self-checking bench for the CAN control and bit-timing block with a far-side bus node.
// Assumes the AXI4-Lite map and latencies of the block; 40 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module ccbt_can_control_bit_timing_tb;
    logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic        s_axi_rready, system_idle, engine_busy, tx_aborts_done, rx_valid_msg, can_rx;
    logic        abort_all_tx, engine_enable, mode_change_flag, rx_timestamp_valid, go;
    logic        filter_count_invalid, wake_line, quantum_tick, triple_sample_sel;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, t, d;
    logic [3:0]  s_axi_wstrb, propagation_seg_len, phase_seg1_len, phase_seg2_len;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic [2:0]  mode_status, jump_width, m;
    logic [15:0] timestamp_timer, rx_timestamp;
    logic [4:0]  filter_data_bit_count, f;
    logic [7:0]  len;
    logic [17:0] ml = {3'h4, 3'h0, 3'h1, 3'h2, 3'h3, 3'h7};
    logic [19:0] fl = {5'h1f, 5'h13, 5'h12, 5'h00};
    int          err_count = 0, checked = 0, i, j, c;
    ccbt_can_control_bit_timing dut (.*);
    ccbt_bus_node node (.aclk(aclk), .go(go), .len(len), .can_rx(can_rx));
    initial begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end
    task automatic conclude;
        begin
            $display("checks %0d errors %0d", checked, err_count);
            if (err_count == 0 && checked > 0)
                $display("*** PASS ***");
            else
                $display("*** FAIL ***");
            $finish;
        end
    endtask
    task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
        begin
            checked++;
            if (g !== e) begin
                err_count++;
                $display("wrong value %s expected %h seen %h", w, e, g);
            end
        end
    endtask
    // A wait that runs out ends the run at once
    task automatic bound(input logic ok);
        begin
            chk("wait", 1, ok);
            if (ok !== 1'b1)
                conclude;
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        logic ta, tw, ok;
        begin
            ok = 1'b0;
            @(posedge aclk);
            s_axi_awaddr <= a;
            s_axi_wdata <= v;
            {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
            for (int n = 0; n < 40 && !ok; n++) begin
                @(negedge aclk);
                ta = s_axi_awready & s_axi_awvalid;
                tw = s_axi_wready & s_axi_wvalid;
                ok = s_axi_bvalid;
                r = s_axi_bresp;
                @(posedge aclk);
                s_axi_awvalid <= s_axi_awvalid & !ta;
                s_axi_wvalid <= s_axi_wvalid & !tw;
                s_axi_bready <= !ok;
            end
            bound(ok);
        end
    endtask
    task automatic rd(input logic [11:0] a);
        logic ta, ok;
        begin
            ok = 1'b0;
            @(posedge aclk);
            s_axi_araddr <= a;
            {s_axi_arvalid, s_axi_rready} <= 2'h3;
            for (int n = 0; n < 40 && !ok; n++) begin
                @(negedge aclk);
                ta = s_axi_arready & s_axi_arvalid;
                ok = s_axi_rvalid;
                d = s_axi_rdata;
                r = s_axi_rresp;
                @(posedge aclk);
                s_axi_arvalid <= s_axi_arvalid & !ta;
                s_axi_rready <= !ok;
            end
            bound(ok);
        end
    endtask
    task automatic rck(input logic [11:0] a, input logic [31:0] k, input logic [31:0] e);
        begin
            rd(a);
            chk("register", e, d & k);
        end
    endtask
    // Automatic phase 2 never drops below the two-quantum processing time
    function automatic logic [3:0] s2(input logic [31:0] v);
        begin
            if (v[15])
                s2 = {1'b0, v[18:16]} + 4'h1;
            else
                s2 = (v[13:11] > 3'h1) ? {1'b0, v[13:11]} + 4'h1 : 4'h2;
        end
    endfunction
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h0;
        {system_idle, engine_busy, tx_aborts_done, rx_valid_msg, go} = 5'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, len} = 64'h0;
        s_axi_wstrb = 4'hf;
        c = $urandom(52918);
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        rck(12'h000, 32'hffffffff, 32'h04800000);
        rck(12'h010, 32'hffffffff, 32'h0);
        rd(12'h030);
        chk("unmapped", 2, r);
        wr(12'h008, 32'h00008000);
        for (i = 0; i < 6; i++) begin
            t = (i == 0) ? 32'h0 : (i == 1) ? 32'hffffffff : ($urandom & 32'hffffffc7);
            t[14] = t[14] & (t[5:0] > 6'h01);
            t[10:8] = t[10:8] | 3'h4;
            if (t[18:16] > t[13:11])
                t[18:16] = t[13:11];
            if ({1'b0, t[7:6]} > t[18:16])
                t[7:6] = t[17:16];
            wr(12'h010, t);
            t = t & 32'h0047ffff;
            rck(12'h010, 32'hffffffff, t);
            chk("prop", {1'b0, t[10:8]} + 4'h1, propagation_seg_len);
            chk("seg1", {1'b0, t[13:11]} + 4'h1, phase_seg1_len);
            chk("seg2", s2(t), phase_seg2_len);
            chk("sjw", t[7:6] + 3'h1, jump_width);
            chk("sam", t[14], triple_sample_sel);
            repeat (2) begin
                @(negedge aclk);
                for (c = 0; c < 300 && quantum_tick !== 1'b1; c++)
                    @(negedge aclk);
            end
            @(negedge aclk);
            for (c = 1; c < 300 && quantum_tick !== 1'b1; c++)
                @(negedge aclk);
            chk("tick", 2 * (t[5:0] + 1), c);
        end
        for (i = 0; i < 6; i++) begin
            m = ml[3 * i +: 3];
            wr(12'h020, 32'h1);
            chk("bresp", 0, r);
            wr(12'h000, {5'h0, m, 24'h008000});
            for (c = 0; c < 20 && mode_status !== m; c++)
                @(negedge aclk);
            bound(mode_status === m);
            rck(12'h020, 32'h1, 32'h1);
            rck(12'h000, 32'h07e00000, {5'h0, m, m, 21'h0});
            wr(12'h010, 32'h43f);
            t = (m == 3'h4) ? 32'h43f : t;
            rck(12'h010, 32'hffffffff, t);
        end
        wr(12'h008, 32'h08000000);
        rck(12'h000, 32'h08000000, 32'h08000000);
        chk("abort out", 1, abort_all_tx);
        tx_aborts_done <= 1'b1;
        rck(12'h000, 32'h08000000, 32'h0);
        tx_aborts_done <= 1'b0;
        wr(12'h008, 32'h00100000);
        rx_valid_msg <= 1'b1;
        @(posedge aclk);
        rx_valid_msg <= 1'b0;
        @(negedge aclk);
        chk("stamp", 1, rx_timestamp_valid);
        chk("stamp value", {16'h0, timestamp_timer - 16'h0001}, rx_timestamp);
        wr(12'h004, 32'h00100000);
        @(negedge aclk);
        d = {16'h0, timestamp_timer};
        repeat (4) @(negedge aclk);
        chk("timer", d, timestamp_timer);
        for (j = 0; j < 2; j++) begin
            wr(j ? 12'h004 : 12'h008, 32'h00002000);
            system_idle <= 1'b1;
            repeat (3) @(negedge aclk);
            chk("idle run", j, engine_enable);
            @(posedge aclk);
            system_idle <= 1'b0;
        end
        engine_busy <= 1'b1;
        wr(12'h004, 32'h00008000);
        rck(12'h000, 32'h00000800, 32'h00000800);
        engine_busy <= 1'b0;
        for (c = 0; c < 20 && d[11] !== 1'b0; c++)
            rd(12'h000);
        bound(d[11] === 1'b0);
        chk("enable", 0, engine_enable);
        for (i = 0; i < 4; i++) begin
            f = fl[5 * i +: 5];
            wr(12'h000, {27'h0200000, f});
            @(negedge aclk);
            chk("count", f, filter_data_bit_count);
            chk("invalid", f > 5'h12, filter_count_invalid);
        end
        for (i = 0; i < 4; i++) begin
            wr(12'h010, {9'h0, i[0], 22'h000400});
            len <= i[1] ? 8'h0c : 8'h02;
            go <= 1'b1;
            @(posedge aclk);
            go <= 1'b0;
            d[0] = 1'b1;
            repeat (20) begin
                @(negedge aclk);
                d[0] = d[0] & wake_line;
            end
            chk("wake", i[0] & ~i[1], d[0]);
        end
        conclude;
    end
endmodule // ccbt_can_control_bit_timing_tb
`default_nettype wire
